// ---- include/drive_cfg_pkg.sv ----
// Constants for the drive configuration parameter bank.
// Assumes a 32-bit register port addressed by parameter index.
package drive_cfg_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // Register indices (word addresses of the communication map)
  localparam logic [9:0] TEC_SEL_ADDR   = 10'h288;
  localparam logic [9:0] ENC_MODE_ADDR  = 10'h28A;
  localparam logic [9:0] RD_FMT_ADDR    = 10'h28C;
  localparam logic [9:0] HOME_CAP_ADDR  = 10'h28E;
  localparam logic [9:0] RSVD_ADDR      = 10'h290;
  localparam logic [9:0] CAM_ALIGN_ADDR = 10'h292;
  localparam logic [9:0] STATUS_ADDR    = 10'h2A0;
  // Field positions
  localparam int TEC_EN_BIT   = 0;
  localparam int JOG_CAM_BIT  = 4;
  localparam int STOP_LVL_BIT = 8;
  localparam int FMT_DIO_BIT  = 0;
  localparam int FMT_COM_BIT  = 1;
  localparam int FMT_NOWARN_BIT = 2;
  // Writable masks, reserved bits read zero
  localparam logic [15:0] TEC_SEL_MASK  = 16'h0111;
  localparam logic [15:0] ENC_MODE_MASK = 16'h0001;
  localparam logic [15:0] RD_FMT_MASK   = 16'h0007;
  localparam logic [15:0] HOME_CAP_MASK = 16'h0001;
  // Reset values, cam clamp limit and home unlock value
  localparam logic [15:0] TEC_SEL_RST   = 16'h0000;
  localparam logic [15:0] ENC_MODE_RST  = 16'h0000;
  localparam logic [15:0] RD_FMT_RST    = 16'h0000;
  localparam logic [31:0] CAM_ALIGN_RST = 32'h00000000;
  localparam logic [31:0] CAM_ALIGN_MAX = 32'h5F3F6F5F;
  localparam logic [15:0] HOME_UNLOCK   = 16'h010F;
  // Fault and warning codes presented on the status output
  localparam logic [9:0] FAULT_ENC_MISMATCH = 10'h069;
  localparam logic [9:0] WARN_UNIT_OVF      = 10'h289;
  localparam logic [9:0] WARN_PULSE_OVF     = 10'h062;
  localparam logic [9:0] CODE_NONE          = 10'h000;
endpackage : drive_cfg_pkg

// ---- src/stop_edge_sel.sv ----
// Stop input conditioning: rising edge or level, by a select bit.
// Assumes stop_input is already synchronous to mclk.
`timescale 1ns/100ps
module stop_edge_sel (
  input  wire logic mclk,       // System clock
  input  wire logic rst,        // Async reset, active high
  input  wire logic level_mode, // 1 level, 0 rising edge
  input  wire logic stop_in,    // Stop input level
  output logic      stop_out    // Conditioned stop request
);
  logic stop_prev_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_prev_reg <= 1'b0;
    end else begin
      stop_prev_reg <= stop_in;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_out <= 1'b0;
    end else begin
      stop_out <= level_mode ? stop_in : (stop_in & ~stop_prev_reg);
    end
  end
endmodule : stop_edge_sel

// ---- src/servo_drive_config_params.sv ----
// Drive configuration parameter bank with its steering logic.
// Assumes a single-cycle strobe register port and synchronous inputs.
`timescale 1ns/100ps
module servo_drive_config_params
  import drive_cfg_pkg::*;
#(
  parameter int POS_W = 32
) (
  input  wire logic                            mclk,        // Clock
  input  wire logic                            rst,         // Async reset
  input  wire logic [drive_cfg_pkg::ADDR_W-1:0] addr,       // Word index
  input  wire logic [drive_cfg_pkg::DATA_W-1:0] wdata,      // Write data
  input  wire logic                            wr_stb,      // Write strobe
  input  wire logic                            rd_stb,      // Read strobe
  output logic [drive_cfg_pkg::DATA_W-1:0]     rdata,       // Read data
  input  wire logic [15:0] special_command_parameter,       // Unlock value
  input  wire logic [31:0] electronic_gear_numerator,       // Gear numerator
  input  wire logic        cam_engaged,                     // Cam active
  input  wire logic        jog_request,                     // Jog requested
  input  wire logic        stop_input,                      // Stop pin
  input  wire logic        home_set_input,                  // Home-set pin
  input  wire logic        motor_is_absolute,               // Motor type
  input  wire logic [POS_W-1:0] current_position,           // Live position
  input  wire logic        user_unit_overflow,              // User-unit ovf
  input  wire logic        pulse_overflow,                  // Pulse ovf
  output logic             tracking_comp_en,                // Comp active
  output logic             jog_enable,                      // Jog accepted
  output logic             stop_request,                    // Stop request
  output logic             absolute_mode,                   // Absolute run
  output logic             dio_unit_pulse,                  // DI/DO in pulses
  output logic             comm_unit_pulse,                 // Comm in pulses
  output logic [9:0]       fault_code,                      // Fault shown
  output logic [9:0]       warn_code,                       // Warning shown
  output logic [POS_W-1:0] home_position,                   // Captured home
  output logic             home_set_pulse,                  // Home recorded
  output logic [31:0]      cam_align_operation              // Cam word
);
  import drive_cfg_pkg::*;

  logic [15:0] tracking_error_comp_select_reg;
  logic [15:0] encoder_position_mode_reg;
  logic [15:0] read_data_format_reg;
  logic [15:0] position_home_capture_reg;
  logic [31:0] cam_align_operation_reg;
  logic        home_fire;
  logic [15:0] wlo;
  logic        tec_sel_we;
  logic        enc_mode_we;
  logic        rd_fmt_we;
  logic        home_cap_we;
  logic        cam_align_we;
  logic        boot_done_reg;
  logic        mode_latched_reg;
  logic [31:0] status_word;
  logic [31:0] rdata_next;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b);
    hit = (a == b) || (a == (b + 10'h001));
  endfunction : hit

  // Reserved bits are dropped at write time so they read zero, except in the unreset encoder mode register before its first write
  function automatic logic [15:0] keep(input logic [15:0] v,
                                       input logic [15:0] m);
    keep = v & m;
  endfunction : keep

  // Warning pick: user-unit overflow ahead of pulse overflow
  function automatic logic [9:0] warn_pick(input logic nowarn,
                                           input logic unit_ovf,
                                           input logic pulse_ovf);
    if (nowarn) begin
      warn_pick = CODE_NONE;
    end else if (unit_ovf) begin
      warn_pick = WARN_UNIT_OVF;
    end else if (pulse_ovf) begin
      warn_pick = WARN_PULSE_OVF;
    end else begin
      warn_pick = CODE_NONE;
    end
  endfunction : warn_pick

  assign wlo = wdata[15:0];

  // One write enable per register; each spans a pair of word indices
  assign tec_sel_we   = wr_stb && hit(addr, TEC_SEL_ADDR);
  assign enc_mode_we  = wr_stb && hit(addr, ENC_MODE_ADDR);
  assign rd_fmt_we    = wr_stb && hit(addr, RD_FMT_ADDR);
  assign home_cap_we  = wr_stb && hit(addr, HOME_CAP_ADDR);
  assign cam_align_we = wr_stb && hit(addr, CAM_ALIGN_ADDR);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tracking_error_comp_select_reg <= TEC_SEL_RST;
    end else if (tec_sel_we) begin
      tracking_error_comp_select_reg <= keep(wlo, TEC_SEL_MASK);
    end
  end

  // Stored mode has no reset: it must outlive rst, which stands in for
  // the power cycle after which a newly written mode takes effect
  always_ff @(posedge mclk) begin
    if (enc_mode_we) begin
      encoder_position_mode_reg <= keep(wlo, ENC_MODE_MASK);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_data_format_reg <= RD_FMT_RST;
    end else if (rd_fmt_we) begin
      read_data_format_reg <= keep(wlo, RD_FMT_MASK);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      position_home_capture_reg <= 16'h0000;
    end else if (home_cap_we) begin
      position_home_capture_reg <= keep(wlo, HOME_CAP_MASK);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cam_align_operation_reg <= CAM_ALIGN_RST;
    end else if (cam_align_we) begin
      cam_align_operation_reg <= (wdata > CAM_ALIGN_MAX) ?
                                 CAM_ALIGN_MAX : wdata;
    end
  end

  // Home capture from register write or digital input
  assign home_fire = (special_command_parameter == HOME_UNLOCK) &&
    ((home_cap_we && wdata[0]) ||
     home_set_input);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      home_set_pulse <= 1'b0;
    end else begin
      home_set_pulse <= home_fire;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      home_position <= '0;
    end else if (home_fire) begin
      home_position <= current_position;
    end
  end

  // Power-up latch of encoder mode, taken on the first edge after reset;
  // a mode never written counts as incremental
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_done_reg    <= 1'b0;
      mode_latched_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      boot_done_reg <= 1'b1;
      if (encoder_position_mode_reg[0]) begin
        mode_latched_reg <= 1'b1;
      end else begin
        mode_latched_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tracking_comp_en <= 1'b0;
    end else begin
      tracking_comp_en <= (electronic_gear_numerator > 32'h00000001) &&
                          tracking_error_comp_select_reg[TEC_EN_BIT];
    end
  end

  // Jog is always allowed while the cam is released
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      jog_enable <= 1'b0;
    end else begin
      jog_enable <= jog_request && (!cam_engaged ||
                    tracking_error_comp_select_reg[JOG_CAM_BIT]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      absolute_mode <= 1'b0;
      fault_code    <= CODE_NONE;
    end else begin
      absolute_mode <= mode_latched_reg && motor_is_absolute;
      fault_code <= (mode_latched_reg && !motor_is_absolute) ?
                    FAULT_ENC_MISMATCH : CODE_NONE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dio_unit_pulse  <= 1'b0;
      comm_unit_pulse <= 1'b0;
    end else begin
      dio_unit_pulse  <= read_data_format_reg[FMT_DIO_BIT];
      comm_unit_pulse <= read_data_format_reg[FMT_COM_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      warn_code <= CODE_NONE;
    end else begin
      warn_code <= warn_pick(read_data_format_reg[FMT_NOWARN_BIT],
                             user_unit_overflow, pulse_overflow);
    end
  end

  stop_edge_sel u_stop (
    .mclk       (mclk),
    .rst        (rst),
    .level_mode (tracking_error_comp_select_reg[STOP_LVL_BIT]),
    .stop_in    (stop_input),
    .stop_out   (stop_request)
  );

  assign cam_align_operation = cam_align_operation_reg;

  // Read-only status snapshot
  assign status_word = {8'h00, fault_code, warn_code, 1'b0,
                        home_set_pulse, absolute_mode, tracking_comp_en};

  // Read mux; unmapped indices and the reserved slot read zero
  always_comb begin
    rdata_next = '0;
    if (hit(addr, TEC_SEL_ADDR)) begin
      rdata_next = {16'h0000, tracking_error_comp_select_reg};
    end else if (hit(addr, ENC_MODE_ADDR)) begin
      rdata_next = {16'h0000, encoder_position_mode_reg};
    end else if (hit(addr, RD_FMT_ADDR)) begin
      rdata_next = {16'h0000, read_data_format_reg};
    end else if (hit(addr, HOME_CAP_ADDR)) begin
      rdata_next = {16'h0000, position_home_capture_reg};
    end else if (hit(addr, CAM_ALIGN_ADDR)) begin
      rdata_next = cam_align_operation_reg;
    end else if (addr == STATUS_ADDR) begin
      rdata_next = status_word;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      rdata <= rdata_next;
    end else begin
      rdata <= '0;
    end
  end
endmodule : servo_drive_config_params

// ---- tb/servo_drive_config_params_asserts.sv ----
// Port-level checks for the drive configuration parameter bank.
// Assumes binding to the bank; sees its ports only.
`timescale 1ns/100ps
module servo_drive_config_params_asserts
  import drive_cfg_pkg::*;
#(
  parameter int POS_W = 32
) (
  input wire logic              mclk,                      // Clock
  input wire logic              rst,                       // Reset
  input wire logic [9:0]        addr,                      // Index
  input wire logic [31:0]       wdata,                     // Write data
  input wire logic              wr_stb,                    // Write
  input wire logic              rd_stb,                    // Read
  input wire logic [31:0]       rdata,                     // Read data
  input wire logic [15:0]       special_command_parameter, // Unlock
  input wire logic [31:0]       electronic_gear_numerator, // Gear
  input wire logic              stop_input,                // Stop pin
  input wire logic              motor_is_absolute,         // Motor type
  input wire logic [POS_W-1:0]  current_position,          // Position
  input wire logic              tracking_comp_en,          // Comp
  input wire logic              stop_request,              // Stop out
  input wire logic              absolute_mode,             // Absolute run
  input wire logic              dio_unit_pulse,            // DIO unit
  input wire logic              comm_unit_pulse,           // Comm unit
  input wire logic [9:0]        fault_code,                // Fault
  input wire logic [9:0]        warn_code,                 // Warning
  input wire logic [POS_W-1:0]  home_position,             // Home
  input wire logic              home_set_pulse,            // Home event
  input wire logic [31:0]       cam_align_operation        // Cam word
);
  logic [1:0] run_cnt_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_cnt_reg <= 2'h0;
    end else if (run_cnt_reg != 2'h3) begin
      run_cnt_reg <= run_cnt_reg + 2'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_rsvd_reads_zero: assert property (
    rd_stb && addr == RSVD_ADDR |=> rdata == 32'h0)
    else $error("reserved slot read not zero");
  chk_home_capture: assert property (
    wr_stb && addr == HOME_CAP_ADDR && wdata[0]
    && special_command_parameter == HOME_UNLOCK
    |=> home_set_pulse && home_position == $past(current_position))
    else $error("home capture not recorded");
  chk_unit_select: assert property (
    wr_stb && addr == RD_FMT_ADDR |-> ##2
    dio_unit_pulse == $past(wdata[0], 2)
    && comm_unit_pulse == $past(wdata[1], 2))
    else $error("unit select outputs wrong");
  chk_cam_clamp: assert property (
    wr_stb && addr == CAM_ALIGN_ADDR |=> cam_align_operation ==
    ($past(wdata) > CAM_ALIGN_MAX ? CAM_ALIGN_MAX : $past(wdata)))
    else $error("cam word not stored or clamped");
  chk_comp_gear: assert property (
    $stable(electronic_gear_numerator)
    && electronic_gear_numerator <= 32'h1 |=> !tracking_comp_en)
    else $error("compensation on with gear not above one");
  chk_enc_fault: assert property (
    motor_is_absolute |=> fault_code == CODE_NONE)
    else $error("mismatch fault with absolute motor");
  chk_warn_off: assert property (
    wr_stb && addr == RD_FMT_ADDR && wdata[2]
    ##1 !(wr_stb && addr == RD_FMT_ADDR) |=> warn_code == CODE_NONE)
    else $error("warning shown while suppressed");
  chk_stop_cause: assert property (
    stop_request |-> $past(stop_input))
    else $error("stop request without stop input");
  chk_mode_hold: assert property (
    run_cnt_reg == 2'h3 && $stable(motor_is_absolute)
    |=> $stable(absolute_mode))
    else $error("encoder mode changed without reset");
endmodule : servo_drive_config_params_asserts

bind servo_drive_config_params servo_drive_config_params_asserts
  #(.POS_W(POS_W)) asrt (.*);

// ---- tb/servo_drive_config_params_tb.sv ----
// Self-checking bench for the drive configuration parameter bank.
// Assumes the port checker is bound from its own file.
`timescale 1ns/100ps
module servo_drive_config_params_tb;
  import drive_cfg_pkg::*;
  logic        mclk, rst, wr_stb, rd_stb, cam_engaged, jog_request;
  logic        stop_input, home_set_input, motor_is_absolute;
  logic        user_unit_overflow, pulse_overflow;
  logic [9:0]  addr;
  logic [31:0] wdata, electronic_gear_numerator, current_position;
  logic [15:0] special_command_parameter;
  wire  [31:0] rdata, home_position, cam_align_operation;
  wire  [9:0]  fault_code, warn_code;
  wire         tracking_comp_en, jog_enable, stop_request, absolute_mode;
  wire         dio_unit_pulse, comm_unit_pulse, home_set_pulse;
  int          miscompares, compares;
  servo_drive_config_params #(.POS_W(32)) dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata),
    .special_command_parameter(special_command_parameter),
    .electronic_gear_numerator(electronic_gear_numerator),
    .cam_engaged(cam_engaged), .jog_request(jog_request),
    .stop_input(stop_input), .home_set_input(home_set_input),
    .motor_is_absolute(motor_is_absolute),
    .current_position(current_position),
    .user_unit_overflow(user_unit_overflow),
    .pulse_overflow(pulse_overflow), .tracking_comp_en(tracking_comp_en),
    .jog_enable(jog_enable), .stop_request(stop_request),
    .absolute_mode(absolute_mode), .dio_unit_pulse(dio_unit_pulse),
    .comm_unit_pulse(comm_unit_pulse), .fault_code(fault_code),
    .warn_code(warn_code), .home_position(home_position),
    .home_set_pulse(home_set_pulse),
    .cam_align_operation(cam_align_operation));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  task automatic final_report;
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic test_regs;
    rd(TEC_SEL_ADDR, 32'h0);
    rd(CAM_ALIGN_ADDR, 32'h0);
    wr(RD_FMT_ADDR, 32'hFFFF);
    rd(RD_FMT_ADDR, 32'h7);
    wr(TEC_SEL_ADDR, 32'hFFFF);
    rd(TEC_SEL_ADDR, 32'h111);
    wr(RSVD_ADDR, 32'hFFFF);
    rd(RSVD_ADDR, 32'h0);
    rd(10'h3FF, 32'h0);
    wr(CAM_ALIGN_ADDR, 32'hFFFFFFFF);
    rd(CAM_ALIGN_ADDR, 32'h5F3F6F5F);
    wr(10'h293, 32'h1234ABCD);
    rd(CAM_ALIGN_ADDR, 32'h1234ABCD);
  endtask : test_regs
  task automatic test_format;
    user_unit_overflow <= 1'b1;
    wr(RD_FMT_ADDR, 32'h1);
    settle;
    chk({dio_unit_pulse, comm_unit_pulse}, 32'h2);
    chk(warn_code, WARN_UNIT_OVF);
    user_unit_overflow <= 1'b0;
    pulse_overflow <= 1'b1;
    wr(RD_FMT_ADDR, 32'h2);
    settle;
    chk({dio_unit_pulse, comm_unit_pulse}, 32'h1);
    chk(warn_code, WARN_PULSE_OVF);
    wr(RD_FMT_ADDR, 32'h4);
    settle;
    chk(warn_code, CODE_NONE);
  endtask : test_format
  task automatic test_comp_jog;
    electronic_gear_numerator <= 32'h2;
    wr(TEC_SEL_ADDR, 32'h11);
    settle;
    chk({tracking_comp_en, jog_enable}, 32'h3);
    electronic_gear_numerator <= 32'h1;
    wr(TEC_SEL_ADDR, 32'h1);
    settle;
    chk({tracking_comp_en, jog_enable}, 32'h0);
  endtask : test_comp_jog
  task automatic test_stop(input logic [31:0] sel, input int exp);
    int n;
    n = 0;
    wr(TEC_SEL_ADDR, sel);
    settle;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      stop_input <= (i < 4);
      #1 n += stop_request;
    end
    chk(n, exp);
  endtask : test_stop
  task automatic test_home;
    current_position <= 32'hA5A51234;
    wr(HOME_CAP_ADDR, 32'h1);
    settle;
    chk(home_position, 32'h0);
    special_command_parameter <= HOME_UNLOCK;
    wr(HOME_CAP_ADDR, 32'h1);
    #1 chk({home_set_pulse, home_position[7:0]}, 32'h134);
    current_position <= 32'h0F0F5A5A;
    home_set_input   <= 1'b1;
    @(posedge mclk);
    home_set_input <= 1'b0;
    settle;
    chk(home_position, 32'h0F0F5A5A);
  endtask : test_home
  task automatic test_enc;
    motor_is_absolute <= 1'b0;
    wr(ENC_MODE_ADDR, 32'h1);
    settle;
    chk({absolute_mode, fault_code}, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    settle;
    chk({absolute_mode, fault_code}, 32'h069);
    motor_is_absolute <= 1'b1;
    settle;
    chk({absolute_mode, fault_code}, 32'h400);
  endtask : test_enc
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {rst, motor_is_absolute} = 2'b11;
    {wr_stb, rd_stb, cam_engaged, jog_request, stop_input} = 5'h06;
    {home_set_input, user_unit_overflow, pulse_overflow} = 3'h0;
    {addr, wdata, electronic_gear_numerator, current_position} = '0;
    special_command_parameter = 16'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    test_regs;
    test_format;
    test_comp_jog;
    test_stop(32'h0, 1);
    test_stop(32'h100, 4);
    test_home;
    test_enc;
    final_report;
  end
  initial begin
    #(4 * 20000);
    miscompares++;
    final_report;
  end
endmodule : servo_drive_config_params_tb
